// *** verilog/serial_shift_pkg.sv ***
// Constants and types of the serial shift control block
package serial_shift_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT = 8'h0C;
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int CTL_SIE = 7;
  localparam int CTL_OIE = 6;
  localparam int CTL_WM_HI = 5;
  localparam int CTL_WM_LO = 4;
  localparam int CTL_CS_HI = 3;
  localparam int CTL_CS_LO = 2;
  localparam int CTL_CLK = 1;
  localparam int CTL_TC = 0;
  // ---------------------------------------------------------------
  // Status and port field positions
  // ---------------------------------------------------------------
  localparam int ST_SIF = 7;
  localparam int ST_OIF = 6;
  localparam int ST_CNT_HI = 3;
  localparam int PT_DAT = 0;
  localparam int PT_CLK = 1;
  localparam int PT_DO = 2;
  localparam int PT_DAT_DIR = 4;
  localparam int PT_CLK_DIR = 5;
  localparam int PT_DO_DIR = 6;
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WM_OFF = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_t;
  typedef enum logic [1:0] {
    CS_SOFT = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } clock_source_t;
endpackage

// *** verilog/serial_shift_control.sv ***
// Universal serial shift control with APB register access
// Notes on behaviour
// - Status low nibble shows the transfer count; software reads and overwrites it.
// - Count advances by one per strobe or timer tick, and on both edges of an external clock.
// - Clock pin still clocks the counter with wire mode zero.
// - Control bit 7 enables start interrupt; pending flag fires at once.
// - Control bit 6 enables overflow interrupt; pending flag fires at once.
// - Wire mode bits 5:4 change outputs and the start flag source; pin inputs always work.
// - Wire mode zero: outputs, clock hold and start detector off.
// - Three-wire: data out replaces port bit; direction bit governs drive.
// - Two-wire: data and clock pins open drain, enabled by direction bits.
// - Two-wire data pin low when shift output or port bit is zero.
// - Two-wire clock low on port zero or start hold until flag cleared.
// - Two-wire mode turns off pull-ups on data and clock pins.
// - Mode three also holds clock low after overflow until flag cleared.
// - Clock select bits 3:2; external clock updates output on opposite edge.
// - Strobe or timer source: output latch transparent, follows shift MSB.
// - Clock select and strobe decode per the source table.
// - Select zero: strobe write shifts once, counts once; reads as zero.
// - Strobe output updates at once; input sampled the cycle before.
// - External source: strobe bit stored, selects toggle strobe counting.
// - Toggle strobe write inverts clock port bit; reads as zero.
// - Overflow flag set on wrap 15 to 0, cleared by writing one.
// - Shift register shifts left; bit 7 feeds the output latch.
`timescale 1ns/1ns
module serial_shift_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Neighbouring logic
  input wire logic timer_match,
  input wire logic start_detect,
  input wire logic global_irq_enable,
  output logic start_irq,
  output logic overflow_irq,
  // Clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic scl_pullup,
  // Data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic sda_pullup,
  // Data out pin
  output logic do_out,
  output logic do_oe_n,
  output logic do_pullup
);
  import serial_shift_pkg::*;

  // ---------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] shift_r;
  logic [7:0] port_r;
  logic [3:0] cnt_r;
  logic sif_r;
  logic oif_r;
  logic dout_r;
  logic [7:0] rd_nxt;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2;
  logic wr, setup, mapped;
  logic wr_ctrl, wr_stat, wr_data, wr_port;
  wire_mode_t wm;
  clock_source_t cs;
  logic ext_src, strobe_sel;
  logic rise, fall, ext_edge;
  logic soft_strobe, toggle_strobe;
  logic sh_tick, cnt_tick, wrap;
  logic latch_open;
  logic two_wire;
  logic clk_low;

  assign wm = wire_mode_t'(ctrl_r[CTL_WM_HI:CTL_WM_LO]);
  assign cs = clock_source_t'(ctrl_r[CTL_CS_HI:CTL_CS_LO]);
  assign ext_src = ctrl_r[CTL_CS_HI];
  assign strobe_sel = ctrl_r[CTL_CLK];
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_STAT) |
                  (paddr == OFS_DATA) | (paddr == OFS_PORT);
  assign wr_ctrl = wr & (paddr == OFS_CTRL);
  assign wr_stat = wr & (paddr == OFS_STAT);
  assign wr_data = wr & (paddr == OFS_DATA);
  assign wr_port = wr & (paddr == OFS_PORT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Reset to the idle high line level, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // Edges of the clock pin, read in every wire mode
  assign rise = scl_s2 & ~scl_s3;
  assign fall = ~scl_s2 & scl_s3;
  assign ext_edge = rise | fall;

  // ---------------------------------------------------------------
  // Clock source decode
  // ---------------------------------------------------------------
  assign soft_strobe = wr_ctrl & pwdata[CTL_CLK] &
                       (pwdata[CTL_CS_HI:CTL_CS_LO] == CS_SOFT);
  assign toggle_strobe = wr_ctrl & pwdata[CTL_TC];

  always_comb begin
    sh_tick = 1'b0;
    cnt_tick = 1'b0;
    unique case (cs)
      CS_SOFT: begin
        sh_tick = soft_strobe;
        cnt_tick = soft_strobe;
      end
      CS_TIMER: begin
        sh_tick = timer_match;
        cnt_tick = timer_match;
      end
      CS_EXT_POS: begin
        sh_tick = rise;
        cnt_tick = strobe_sel ? toggle_strobe : ext_edge;
      end
      CS_EXT_NEG: begin
        sh_tick = fall;
        cnt_tick = strobe_sel ? toggle_strobe : ext_edge;
      end
    endcase
  end

  assign wrap = cnt_tick & (cnt_r == CNT_MAX) & ~wr_stat;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= {pwdata[CTL_SIE:CTL_CLK], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Transfer counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CNT_RST;
    end else if (wr_stat) begin
      cnt_r <= pwdata[ST_CNT_HI:0];
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Flags, start set wins over clear; a status write blocks the overflow set
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oif_r <= 1'b0;
    end else if (wrap) begin
      oif_r <= 1'b1;
    end else if (wr_stat & pwdata[ST_OIF]) begin
      oif_r <= 1'b0;
    end
  end

  logic sif_set;
  assign sif_set = two_wire ? start_detect : (ext_src & ~strobe_sel & ext_edge);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif_r <= 1'b0;
    end else if (sif_set) begin
      sif_r <= 1'b1;
    end else if (wr_stat & pwdata[ST_SIF]) begin
      sif_r <= 1'b0;
    end
  end

  assign start_irq = sif_r & ctrl_r[CTL_SIE] & global_irq_enable;
  assign overflow_irq = oif_r & ctrl_r[CTL_OIE] & global_irq_enable;

  // ---------------------------------------------------------------
  // Shift register and output latch
  // ---------------------------------------------------------------
  logic [7:0] shift_nxt;
  always_comb begin
    shift_nxt = shift_r;
    if (wr_data) begin
      shift_nxt = pwdata[7:0];
    end else if (sh_tick) begin
      shift_nxt = {shift_r[6:0], sda_s2};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= DATA_RST;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Open in the second half of an external clock cycle, always for internal
  always_comb begin
    unique case (cs)
      CS_EXT_POS: latch_open = ~scl_s2;
      CS_EXT_NEG: latch_open = scl_s2;
      default: latch_open = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 1'b0;
    end else if (latch_open) begin
      dout_r <= shift_nxt[7];
    end
  end

  // ---------------------------------------------------------------
  // Port and direction register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_r <= PORT_RST;
    end else begin
      if (wr_port) begin
        port_r <= pwdata[7:0];
      end
      if (toggle_strobe & ~wr_port) begin
        port_r[PT_CLK] <= ~port_r[PT_CLK];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  assign two_wire = (wm == WM_TWO) | (wm == WM_TWO_HOLD);
  assign clk_low = ~port_r[PT_CLK] | sif_r | ((wm == WM_TWO_HOLD) & oif_r);

  always_comb begin
    scl_out = port_r[PT_CLK];
    scl_oe_n = ~port_r[PT_CLK_DIR];
    sda_out = port_r[PT_DAT];
    sda_oe_n = ~port_r[PT_DAT_DIR];
    do_out = port_r[PT_DO];
    do_oe_n = ~port_r[PT_DO_DIR];
    scl_pullup = ~port_r[PT_CLK_DIR] & port_r[PT_CLK];
    sda_pullup = ~port_r[PT_DAT_DIR] & port_r[PT_DAT];
    do_pullup = ~port_r[PT_DO_DIR] & port_r[PT_DO];
    unique case (wm)
      WM_OFF: begin
        scl_out = port_r[PT_CLK];
      end
      WM_THREE: begin
        do_out = dout_r;
      end
      WM_TWO, WM_TWO_HOLD: begin
        scl_out = 1'b0;
        sda_out = 1'b0;
        scl_oe_n = ~(port_r[PT_CLK_DIR] & clk_low);
        sda_oe_n = ~(port_r[PT_DAT_DIR] & (~dout_r | ~port_r[PT_DAT]));
        scl_pullup = 1'b0;
        sda_pullup = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    if (paddr == OFS_CTRL) begin
      rd_nxt = {ctrl_r[CTL_SIE:CTL_CS_LO], 2'b00};
    end else if (paddr == OFS_STAT) begin
      rd_nxt = {sif_r, oif_r, 2'b00, cnt_r};
    end else if (paddr == OFS_DATA) begin
      rd_nxt = shift_r;
    end else if (paddr == OFS_PORT) begin
      rd_nxt = port_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= {24'h00_0000, rd_nxt};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cnt_write: assert property (wr_stat |=> cnt_r == $past(pwdata[ST_CNT_HI:0]))
    else $error("counter write lost");
  chk_cnt_step: assert property (cnt_tick && !wr_stat |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("counter did not step by one");
  chk_ovf_set: assert property (wrap |=> oif_r)
    else $error("overflow flag not set on wrap");
  chk_ovf_keep: assert property (oif_r && !(wr_stat && pwdata[ST_OIF]) |=> oif_r)
    else $error("overflow flag dropped without clear");
  chk_start_irq: assert property ($rose(ctrl_r[CTL_SIE]) && sif_r && global_irq_enable
    |-> start_irq)
    else $error("pending start interrupt not raised");
  chk_ovf_irq: assert property ($rose(global_irq_enable) && oif_r && ctrl_r[CTL_OIE]
    |-> overflow_irq)
    else $error("pending overflow interrupt not raised");
  chk_hold_scl: assert property (wm == WM_TWO_HOLD && port_r[PT_CLK_DIR] && oif_r
    |-> !scl_oe_n)
    else $error("clock not held after overflow");
  chk_sda_low: assert property (two_wire && port_r[PT_DAT_DIR] && !dout_r |-> !sda_oe_n)
    else $error("data pin not pulled low");
  chk_toggle_port: assert property (toggle_strobe && !wr_port
    |=> port_r[PT_CLK] != $past(port_r[PT_CLK]))
    else $error("toggle strobe did not invert clock port");
  chk_mode_off: assert property (wm == WM_OFF |-> scl_oe_n == !port_r[PT_CLK_DIR]
    && do_out == port_r[PT_DO])
    else $error("pins not plain port lines in mode zero");
  chk_strobe_rd: assert property (setup && !pwrite && paddr == OFS_CTRL
    |=> prdata[1:0] == 2'b00)
    else $error("strobe bits read nonzero");
  chk_latch_hold: assert property (!latch_open |=> dout_r == $past(dout_r))
    else $error("output latch changed while closed");
  chk_latch_pass: assert property (latch_open |=> dout_r == $past(shift_nxt[7]))
    else $error("open latch did not pass the shift msb");
  chk_shift_left: assert property (sh_tick && !wr_data
    |=> shift_r == {$past(shift_r[6:0]), $past(sda_s2)})
    else $error("shift register did not shift left");
  chk_pull_off: assert property (two_wire |-> !scl_pullup && !sda_pullup)
    else $error("pull-ups left on in two-wire mode");
  chk_start_set: assert property (sif_set |=> sif_r)
    else $error("start flag not set");
  chk_three_do: assert property (wm == WM_THREE
    |-> do_out == dout_r && do_oe_n == !port_r[PT_DO_DIR])
    else $error("data out pin not fed from the latch");
  chk_sda_free: assert property (two_wire && dout_r && port_r[PT_DAT] |-> sda_oe_n)
    else $error("data pin driven while both sources are one");
endmodule // serial_shift_control

// *** testbench/serial_peer.sv ***
// Serial peer model that drives the clock and data lines of the bus
`timescale 1ns/1ns
module serial_peer (
  // Device side of the pins
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Resolved line levels
  output logic scl_line,
  output logic sda_line
);
  logic scl_drv;
  logic sda_drv;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // ---------------------------------------------------------------
  // Wired lines with pull-up, a low from either party wins
  // ---------------------------------------------------------------
  assign scl_line = scl_drv & ~(~scl_oe_n & ~scl_out);
  assign sda_line = sda_drv & ~(~sda_oe_n & ~sda_out);
  // Clock runs only inside a frame; data moves mid low phase, MSB first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      scl_drv = 1'b0;
      #100;
      sda_drv = b[i];
      #100;
      scl_drv = 1'b1;
      #200;
    end
    sda_drv = 1'b1;
  endtask
endmodule // serial_peer

// *** testbench/testbench.sv ***
// Self-checking bench for the serial shift control block
`timescale 1ns/1ns
module testbench;
  import serial_shift_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic timer_match, start_detect, global_irq_enable, start_irq, overflow_irq;
  logic scl_in, scl_out, scl_oe_n, scl_pullup, sda_in, sda_out, sda_oe_n, sda_pullup;
  logic do_out, do_oe_n, do_pullup;
  logic [31:0] exp_q[$];
  logic [7:0] d;
  int fail_count, n_tests, n;

  serial_shift_control u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_match(timer_match), .start_detect(start_detect),
    .global_irq_enable(global_irq_enable), .start_irq(start_irq),
    .overflow_irq(overflow_irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .scl_pullup(scl_pullup), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .sda_pullup(sda_pullup), .do_out(do_out), .do_oe_n(do_oe_n), .do_pullup(do_pullup)
  );
  serial_peer u_peer (
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl_line(scl_in), .sda_line(sda_in)
  );

  always #25 pclk = ~pclk;

  // ---------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    check(32'(got), 32'(exp));
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic tk);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, v};
    @(posedge pclk);
    penable <= 1'b1;
    timer_match <= tk;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    timer_match <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, v, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    apb(1'b0, a, 8'h00, 1'b0);
  endtask
  task automatic tick(input logic tm);
    @(posedge pclk);
    if (tm) timer_match <= 1'b1;
    else start_detect <= 1'b1;
    @(posedge pclk);
    timer_match <= 1'b0;
    start_detect <= 1'b0;
  endtask

  // Read results and error responses taken at the completing edge
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check(32'(pslverr), 32'(paddr > OFS_PORT));
      if (!pwrite && exp_q.size() > 0) check(prdata, exp_q.pop_front());
      else if (!pwrite) check(prdata, 32'hFFFF_FFFF);
    end
  end

  initial begin
    #500_000;
    fail_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    timer_match = 1'b0;
    start_detect = 1'b0;
    global_irq_enable = 1'b0;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(32'h03f8));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_STAT, 8'h00);
    rd(OFS_DATA, DATA_RST);
    rd(OFS_PORT, PORT_RST);
    rd(8'h10, 8'h00);
    @(negedge pclk);
    pin(scl_oe_n, 1'b1);
    pin(sda_oe_n, 1'b1);
    pin(do_oe_n, 1'b1);
    d = 8'($urandom);
    n = 1 + int'($urandom % 5);
    wr(OFS_DATA, d);
    for (int i = 0; i < n; i++) begin
      wr(OFS_CTRL, 8'h02);
      d = {d[6:0], 1'b1};
    end
    wr(OFS_CTRL, 8'h00);
    rd(OFS_DATA, d);
    rd(OFS_STAT, {4'h0, 4'(n)});
    rd(OFS_CTRL, 8'h00);
    wr(OFS_STAT, 8'h0F);
    wr(OFS_CTRL, 8'h42);
    rd(OFS_STAT, 8'h40);
    @(negedge pclk);
    pin(overflow_irq, 1'b0);
    @(posedge pclk);
    global_irq_enable <= 1'b1;
    @(negedge pclk);
    pin(overflow_irq, 1'b1);
    wr(OFS_STAT, 8'h00);
    rd(OFS_STAT, 8'h40);
    wr(OFS_STAT, 8'h40);
    rd(OFS_STAT, 8'h00);
    @(negedge pclk);
    pin(overflow_irq, 1'b0);
    wr(OFS_CTRL, 8'h04);
    for (int i = 0; i < 3; i++) tick(1'b1);
    rd(OFS_STAT, 8'h03);
    apb(1'b1, OFS_STAT, 8'h05, 1'b1);
    rd(OFS_STAT, 8'h05);
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h08);
    d = 8'($urandom);
    @(negedge pclk);
    u_peer.send_byte(d);
    repeat (8) @(posedge pclk);
    rd(OFS_DATA, d);
    rd(OFS_STAT, 8'hC0);
    wr(OFS_STAT, 8'hC0);
    // Falling edges sample the idle high first, then bits 7 down to 1
    wr(OFS_CTRL, 8'h0C);
    d = 8'($urandom);
    @(negedge pclk);
    u_peer.send_byte(d);
    repeat (8) @(posedge pclk);
    rd(OFS_DATA, {1'b1, d[7:1]});
    rd(OFS_STAT, 8'hC0);
    wr(OFS_STAT, 8'hC0);
    wr(OFS_CTRL, 8'h0A);
    wr(OFS_PORT, 8'h20);
    rd(OFS_CTRL, 8'h08);
    for (int i = 0; i < 3; i++) wr(OFS_CTRL, 8'h0B);
    rd(OFS_STAT, 8'h03);
    rd(OFS_PORT, 8'h22);
    @(negedge pclk);
    pin(scl_out, 1'b1);
    pin(scl_oe_n, 1'b0);
    wr(OFS_CTRL, 8'h10);
    wr(OFS_PORT, 8'h40);
    wr(OFS_DATA, 8'h80);
    @(negedge pclk);
    pin(do_out, 1'b1);
    pin(do_oe_n, 1'b0);
    wr(OFS_DATA, 8'h40);
    @(negedge pclk);
    pin(do_out, 1'b0);
    wr(OFS_CTRL, 8'h12);
    @(negedge pclk);
    pin(do_out, 1'b1);
    wr(OFS_CTRL, 8'h20);
    wr(OFS_PORT, 8'h33);
    wr(OFS_DATA, 8'h80);
    @(negedge pclk);
    pin(sda_oe_n, 1'b1);
    pin(scl_oe_n, 1'b1);
    pin(sda_pullup, 1'b0);
    pin(scl_pullup, 1'b0);
    wr(OFS_DATA, 8'h00);
    @(negedge pclk);
    pin(sda_oe_n, 1'b0);
    pin(sda_out, 1'b0);
    wr(OFS_PORT, 8'h31);
    @(negedge pclk);
    pin(scl_oe_n, 1'b0);
    wr(OFS_PORT, 8'h33);
    tick(1'b0);
    @(negedge pclk);
    pin(scl_oe_n, 1'b0);
    pin(start_irq, 1'b0);
    wr(OFS_CTRL, 8'hA0);
    @(negedge pclk);
    pin(start_irq, 1'b1);
    wr(OFS_STAT, 8'h80);
    @(negedge pclk);
    pin(scl_oe_n, 1'b1);
    pin(start_irq, 1'b0);
    wr(OFS_STAT, 8'h0F);
    wr(OFS_CTRL, 8'h32);
    @(negedge pclk);
    pin(scl_oe_n, 1'b0);
    wr(OFS_STAT, 8'h40);
    @(negedge pclk);
    pin(scl_oe_n, 1'b1);
    wr(OFS_CTRL, 8'h00);
    tick(1'b0);
    rd(OFS_STAT, 8'h00);
    wrap_up();
  end
endmodule // testbench
